// [design/out_fault_pkg.sv]
// constants shared by the discrete output fault control block
`default_nettype none
package out_fault_pkg;
	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int NUM_POINTS = 32;
	localparam int GROUP_POINTS = 16;
	localparam int NUM_GROUPS = 2;
	localparam int SYNC_W = NUM_POINTS + NUM_GROUPS + 2;
	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_OUT_CMD = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_EVENT = 8'h0c;
	localparam logic [7:0] OFS_FAULT = 8'h10;
	localparam logic [7:0] OFS_DRIVE = 8'h14;
	localparam logic [7:0] OFS_TIMEOUT = 8'h18;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_HOLD_BIT = 0;
	localparam int CTRL_MODFLT_BIT = 1;
	localparam int ST_PWR_BIT = 0;
	localparam int ST_LOCK_BIT = 2;
	localparam int ST_SW_HOLD_BIT = 3;
	localparam int ST_MISMATCH_BIT = 4;
	localparam int ST_PROT_BIT = 5;
	localparam int ST_LOST_BIT = 7;
	localparam int ST_HOLDOFF_BIT = 8;
	localparam int EV_PWR_LOSS_BIT = 0;
	localparam int EV_INSERT_BIT = 2;
	localparam int EV_REMOVE_BIT = 3;
	localparam int EV_W = 4;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [31:0] OUT_CMD_RST = 32'h0000_0000;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [EV_W-1:0] EV_RST = 4'h0;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int COMM_LOSS_MS = 400;
	localparam int COMM_LOSS_CYCLES = COMM_LOSS_MS * (CLK_HZ / 1000);
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYCLES = BLINK_MS * (CLK_HZ / 1000);
endpackage
`default_nettype wire

// [design/bit_sync.sv]
// two-flop synchroniser bank for field-side status inputs
`default_nettype none
module bit_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] stage1_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			stage1_r <= '0;
			q <= '0;
		end else if (ce) begin
			stage1_r <= d;
			q <= stage1_r;
		end
	end
endmodule
`default_nettype wire

// [design/comm_watchdog.sv]
// communication loss timer, restarted by each output data update
`default_nettype none
module comm_watchdog (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// control
	input wire logic kick,
	input wire logic [31:0] limit,
	// status
	output logic lost
);
	logic [31:0] cnt_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= 32'h0;
			lost <= 1'b0;
		end else if (ce) begin
			if (kick) begin
				cnt_r <= 32'h0;
				lost <= 1'b0;
			end else if (cnt_r >= limit) begin
				lost <= 1'b1;
			end else begin
				cnt_r <= cnt_r + 32'h1;
			end
		end
	end
endmodule
`default_nettype wire

// [design/out_fault_ctrl.sv]
// discrete output fault control: bus slave, output gating, faults and indicators
// Notes on behaviour
// - 32 outputs in two independently powered groups of 16, tracked per group.
// - each point flags a fault while its driver reports overcurrent or short.
// - report field power loss, group protection failure, block lock, mode mismatch.
// - point fault holds until driver stops reporting or point is commanded off.
// - after overload clears, output returns to its pre-fault commanded state.
// - point indicator green when on, yellow when faulted, dark when off.
// - group indicator green with power, yellow on group fault, dark without power.
// - block indicator green locked, red unlocked, blinking on module fault.
// - each lock change sends an inserted or removed message.
// - force off mode drives all outputs to zero on communication loss.
// - hold mode keeps last commanded outputs on loss while field power present.
// - default mode comes from upper switch: open forces off, left holds.
// - software default mode must match switch; mismatch raises a fault.
// - a module fault forces all outputs to zero.
// - field power loss reported, outputs off, kept off until fresh data.
// - without field power point indicators show the commanded state.
// - force off: outputs off within 400 ms of loss, indicators off.
// - hold mode: outputs held until new data, indicators off.
`default_nettype none
module out_fault_ctrl
	import out_fault_pkg::*;
#(
	parameter logic [31:0] COMM_TIMEOUT = 32'(COMM_LOSS_CYCLES),
	parameter logic [31:0] BLINK_HALF = 32'(BLINK_CYCLES)
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// field side status
	input wire logic [out_fault_pkg::NUM_POINTS-1:0] drv_fault,
	input wire logic [out_fault_pkg::NUM_GROUPS-1:0] field_pwr_good,
	input wire logic block_locked,
	input wire logic dip_upper_open,
	// outputs
	output logic [out_fault_pkg::NUM_POINTS-1:0] out_drive,
	// indicators
	output logic [out_fault_pkg::NUM_POINTS-1:0] point_led_green,
	output logic [out_fault_pkg::NUM_POINTS-1:0] point_led_yellow,
	output logic [out_fault_pkg::NUM_GROUPS-1:0] group_led_green,
	output logic [out_fault_pkg::NUM_GROUPS-1:0] group_led_yellow,
	output logic block_led_green,
	output logic block_led_red,
	// messages to the controller
	output logic block_inserted_message,
	output logic block_removed_message
);
	import out_fault_pkg::*;
	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [NUM_POINTS-1:0] group_mask(input logic [NUM_GROUPS-1:0] g);
		logic [NUM_POINTS-1:0] m;
		m = '0;
		for (int i = 0; i < NUM_POINTS; i++) begin
			m[i] = g[i / GROUP_POINTS];
		end
		return m;
	endfunction

	// ------------------------------------------------------------
	// synchronisers and switch
	// ------------------------------------------------------------
	logic [SYNC_W-1:0] sync_q;
	logic [NUM_POINTS-1:0] fault_s;
	logic [NUM_GROUPS-1:0] pwr_s;
	logic lock_s;
	logic sw_force_off;

	bit_sync #(.W(SYNC_W)) u_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.d({dip_upper_open, block_locked, field_pwr_good, drv_fault}),
		.q(sync_q)
	);

	assign fault_s = sync_q[NUM_POINTS-1:0];
	assign pwr_s = sync_q[NUM_POINTS +: NUM_GROUPS];
	assign lock_s = sync_q[NUM_POINTS+NUM_GROUPS];
	assign sw_force_off = sync_q[NUM_POINTS+NUM_GROUPS+1];

	// ------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------
	logic req;
	logic wr;
	logic [31:0] cmd_r;
	logic [1:0] ctrl_r;
	logic [31:0] timeout_r;
	logic [EV_W-1:0] ev_r;
	logic [EV_W-1:0] ev_set;
	logic [EV_W-1:0] ev_nxt;
	logic [31:0] rd_nxt;
	logic [31:0] status;
	logic cmd_wr;
	logic [NUM_POINTS-1:0] point_fault_r;

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i;
	assign cmd_wr = wr && (wb_adr_i == OFS_OUT_CMD);

	always_ff @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else if (ce) begin
			wb_ack_o <= req;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cmd_r <= OUT_CMD_RST;
			ctrl_r <= CTRL_RST;
			timeout_r <= COMM_TIMEOUT;
		end else if (ce && wr) begin
			if (wb_adr_i == OFS_OUT_CMD) begin
				cmd_r <= merge_bytes(cmd_r, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == OFS_CTRL) begin
				ctrl_r <= 2'(merge_bytes({30'h0, ctrl_r}, wb_dat_i, wb_sel_i));
			end
			if (wb_adr_i == OFS_TIMEOUT) begin
				timeout_r <= merge_bytes(timeout_r, wb_dat_i, wb_sel_i);
			end
		end
	end

	always_comb begin
		unique case (wb_adr_i)
			OFS_OUT_CMD: rd_nxt = cmd_r;
			OFS_CTRL: rd_nxt = {30'h0, ctrl_r};
			OFS_STATUS: rd_nxt = status;
			OFS_EVENT: rd_nxt = {28'h0, ev_r};
			OFS_FAULT: rd_nxt = point_fault_r;
			OFS_DRIVE: rd_nxt = out_drive;
			OFS_TIMEOUT: rd_nxt = timeout_r;
			default: rd_nxt = 32'h0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wb_dat_o <= 32'h0;
		end else if (ce && req && !wb_we_i) begin
			wb_dat_o <= rd_nxt;
		end
	end

	// ------------------------------------------------------------
	// communication watchdog
	// ------------------------------------------------------------
	logic comm_lost;
	comm_watchdog u_wdog (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.kick(cmd_wr),
		.limit(timeout_r),
		.lost(comm_lost)
	);

	// ------------------------------------------------------------
	// field power tracking and events
	// ------------------------------------------------------------
	logic [NUM_GROUPS-1:0] pwr_prev_r;
	logic [NUM_GROUPS-1:0] hold_off_r;
	logic lock_prev_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			pwr_prev_r <= '0;
			lock_prev_r <= 1'b0;
			hold_off_r <= '1;
		end else if (ce) begin
			pwr_prev_r <= pwr_s;
			lock_prev_r <= lock_s;
			for (int g = 0; g < NUM_GROUPS; g++) begin
				if (!pwr_s[g]) begin
					hold_off_r[g] <= 1'b1;
				end else if (cmd_wr) begin
					hold_off_r[g] <= 1'b0;
				end
			end
		end
	end

	always_comb begin
		ev_set = '0;
		ev_set[EV_PWR_LOSS_BIT +: NUM_GROUPS] = pwr_prev_r & ~pwr_s;
		ev_set[EV_INSERT_BIT] = lock_s && !lock_prev_r;
		ev_set[EV_REMOVE_BIT] = !lock_s && lock_prev_r;
		ev_nxt = ev_r;
		if (wr && (wb_adr_i == OFS_EVENT) && wb_sel_i[0]) begin
			ev_nxt = ev_r & ~wb_dat_i[EV_W-1:0];
		end
		ev_nxt = ev_nxt | ev_set;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ev_r <= EV_RST;
			block_inserted_message <= 1'b0;
			block_removed_message <= 1'b0;
		end else if (ce) begin
			ev_r <= ev_nxt;
			block_inserted_message <= ev_set[EV_INSERT_BIT];
			block_removed_message <= ev_set[EV_REMOVE_BIT];
		end
	end

	// ------------------------------------------------------------
	// output gating and faults
	// ------------------------------------------------------------
	logic module_fault;
	logic mismatch_r;
	logic [NUM_POINTS-1:0] pwr_ok_mask;
	logic [NUM_POINTS-1:0] drive_nxt;
	logic [NUM_GROUPS-1:0] grp_fault;

	assign module_fault = ctrl_r[CTRL_MODFLT_BIT];
	assign pwr_ok_mask = group_mask(pwr_s & ~hold_off_r);

	always_comb begin
		drive_nxt = cmd_r & pwr_ok_mask;
		if (module_fault) begin
			drive_nxt = '0;
		end
		if (comm_lost && sw_force_off) begin
			drive_nxt = '0;
		end
	end

	always_comb begin
		for (int g = 0; g < NUM_GROUPS; g++) begin
			grp_fault[g] = |point_fault_r[g*GROUP_POINTS +: GROUP_POINTS];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			out_drive <= '0;
			point_fault_r <= '0;
			mismatch_r <= 1'b0;
		end else if (ce) begin
			out_drive <= drive_nxt;
			point_fault_r <= fault_s & cmd_r;
			mismatch_r <= ctrl_r[CTRL_HOLD_BIT] == sw_force_off;
		end
	end

	assign status = {22'h0, hold_off_r, comm_lost, grp_fault, mismatch_r, !sw_force_off,
		lock_s, pwr_s};

	// ------------------------------------------------------------
	// indicators
	// ------------------------------------------------------------
	logic [31:0] blink_cnt_r;
	logic blink_r;
	logic [NUM_POINTS-1:0] pwr_pt;
	assign pwr_pt = group_mask(pwr_s);

	always_ff @(posedge clk) begin
		if (rst) begin
			blink_cnt_r <= 32'h0;
			blink_r <= 1'b0;
		end else if (ce) begin
			if (blink_cnt_r >= BLINK_HALF - 32'h1) begin
				blink_cnt_r <= 32'h0;
				blink_r <= !blink_r;
			end else begin
				blink_cnt_r <= blink_cnt_r + 32'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			point_led_green <= '0;
			point_led_yellow <= '0;
			group_led_green <= '0;
			group_led_yellow <= '0;
			block_led_green <= 1'b0;
			block_led_red <= 1'b0;
		end else if (ce) begin
			if (comm_lost) begin
				point_led_green <= '0;
				point_led_yellow <= '0;
				group_led_green <= '0;
				group_led_yellow <= '0;
				block_led_green <= 1'b0;
				block_led_red <= 1'b0;
			end else begin
				point_led_yellow <= point_fault_r & pwr_pt;
				point_led_green <= (drive_nxt & ~point_fault_r & pwr_pt)
					| (cmd_r & ~pwr_pt);
				group_led_yellow <= pwr_s & grp_fault;
				group_led_green <= pwr_s & ~grp_fault;
				block_led_green <= lock_s && !(module_fault && blink_r);
				block_led_red <= !lock_s && !(module_fault && blink_r);
			end
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_ACK_ONE: assert property (ce && wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	AST_ACK_RESP: assert property (ce && req |=> wb_ack_o)
		else $error("request not acknowledged next cycle");
	AST_FAULT_CLEAR: assert property (ce && !cmd_r[0] |=> !point_fault_r[0])
		else $error("fault kept on a point commanded off");
	AST_FAULT_SET: assert property (ce && cmd_r[5] && fault_s[5] |=> point_fault_r[5])
		else $error("driver fault not flagged");
	AST_FORCE_OFF: assert property (ce && comm_lost && sw_force_off |=> out_drive == '0)
		else $error("outputs not forced off on comm loss");
	AST_MODFLT: assert property (ce && module_fault |=> out_drive == '0)
		else $error("outputs on during module fault");
	AST_PWR_OFF: assert property (ce && !pwr_s[1] |=> ##1 out_drive[31:16] == '0)
		else $error("group 2 outputs on without field power");
	AST_HOLD: assert property (ce && comm_lost && !sw_force_off && !module_fault
		&& pwr_s == '1 && hold_off_r == '0 |=> out_drive == $past(cmd_r))
		else $error("outputs not held in hold mode");
	AST_LED_OFF: assert property (ce && comm_lost |=> point_led_green == '0
		&& group_led_green == '0 && !block_led_green)
		else $error("indicators lit during comm loss");
	AST_INSERT: assert property (ce && lock_s && !lock_prev_r |=> block_inserted_message)
		else $error("insert message missing");
	AST_MISMATCH: assert property (ce && (ctrl_r[CTRL_HOLD_BIT] == sw_force_off)
		|=> mismatch_r)
		else $error("mode mismatch not reported");

	COV_FORCE_OFF: cover property (comm_lost && sw_force_off && cmd_r != '0);
	COV_INSERT: cover property (block_inserted_message);
	COV_POINT_FAULT: cover property (point_fault_r != '0);
	COV_PWR_LOSS: cover property (ev_r[EV_PWR_LOSS_BIT]);
endmodule
`default_nettype wire

// [tb/cpu_bus_model.sv]
// controller-side wishbone master model for the output fault block
`default_nettype none
module cpu_bus_model (
	// clock
	input wire logic clk,
	// wishbone master
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat,
	input wire logic ack,
	input wire logic [31:0] rdat,
	// status
	output logic no_answer
);
	timeunit 1ns;
	timeprecision 1ps;
	import out_fault_pkg::*;
	// ------------------------------------------------------------
	// bus cycles
	// ------------------------------------------------------------
	initial begin
		{cyc, stb, we, no_answer} = 4'h0;
		adr = 8'h00;
		sel = 4'h0;
		dat = 32'h0000_0000;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		// released lines do not keep the last value
		adr <= ~a;
		dat <= ~d;
		@(posedge clk);
		// the slave must drop ack in the cycle after it gave it
		if (ack !== 1'b0) begin
			no_answer <= 1'b1;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0000_0000, q);
	endtask
	// software default mode kept equal to the switch
	task automatic set_mode(input logic dip_open);
		wr(OFS_CTRL, {31'h0, ~dip_open});
	endtask
endmodule
`default_nettype wire

// [tb/out_fault_ctrl_tb.sv]
// self-checking bench for the discrete output fault control block
`default_nettype none
module out_fault_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import out_fault_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clk, rst, ce, cyc, stb, we, ack, locked, dip, ins, rem, bg, br, no_answer;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q, cmd, drv, drive, pg, py;
	logic [1:0] pwr, gg, gy;
	int err_count = 0;
	int checks_done = 0;
	int ins_n = 0;
	int rem_n = 0;
	int on_n;
	// ------------------------------------------------------------
	// design and controller model
	// ------------------------------------------------------------
	out_fault_ctrl #(.COMM_TIMEOUT(32'h0000_1388), .BLINK_HALF(32'h0000_0004)) u_out_fault_ctrl (
		.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.drv_fault(drv), .field_pwr_good(pwr), .block_locked(locked), .dip_upper_open(dip),
		.out_drive(drive), .point_led_green(pg), .point_led_yellow(py),
		.group_led_green(gg), .group_led_yellow(gy), .block_led_green(bg),
		.block_led_red(br), .block_inserted_message(ins), .block_removed_message(rem));
	cpu_bus_model u_cpu_bus_model (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.sel(sel), .dat(wdat), .ack(ack), .rdat(rdat), .no_answer(no_answer));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (ins === 1'b1) ins_n <= ins_n + 1;
		if (rem === 1'b1) rem_n <= rem_n + 1;
	end
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_cpu_bus_model.wr(a, d);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		u_cpu_bus_model.rd(a, q);
		chk(q, exp);
	endtask
	task automatic conclude();
		if (err_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		wait_n(20000);
		err_count++;
		conclude();
	end
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		drv = 32'h0;
		pwr = 2'h3;
		locked = 1'b0;
		dip = 1'b1;
		wait_n(6);
		rst <= 1'b0;
		wait_n(4);
		// reset state, hold-off, unmapped place
		rd_chk(OFS_DRIVE, 32'h0);
		rd_chk(OFS_STATUS, 32'h0000_0303);
		wr(8'h40, 32'hffff_ffff);
		rd_chk(8'h40, 32'h0);
		cmd = 32'ha5a5_0f0f;
		wr(OFS_OUT_CMD, cmd);
		wait_n(3);
		chk(drive, cmd);
		chk(pg, cmd);
		chk({30'h0, gg}, 32'h3);
		// upper group loses field power
		pwr <= 2'h1;
		wait_n(5);
		chk(drive, cmd & 32'h0000_ffff);
		chk(pg, cmd);
		chk({30'h0, gg}, 32'h1);
		rd_chk(OFS_EVENT, 32'h2);
		wr(OFS_EVENT, 32'hf);
		pwr <= 2'h3;
		wait_n(5);
		chk(drive, cmd & 32'h0000_ffff);
		wr(OFS_OUT_CMD, cmd);
		wait_n(3);
		chk(drive, cmd);
		// point overload, recovery, then commanded off while faulted
		drv <= 32'h1;
		wait_n(5);
		chk(py, 32'h1);
		chk({30'h0, gy}, 32'h1);
		rd_chk(OFS_FAULT, 32'h1);
		drv <= 32'h0;
		wait_n(5);
		chk(py, 32'h0);
		chk(drive, cmd);
		drv <= 32'h1;
		wait_n(5);
		cmd = cmd & ~32'h1;
		wr(OFS_OUT_CMD, cmd);
		wait_n(4);
		chk(py, 32'h0);
		drv <= 32'h0;
		// terminal block lock changes
		locked <= 1'b1;
		wait_n(5);
		chk(32'(ins_n), 32'h1);
		chk({30'h0, bg, br}, 32'h2);
		locked <= 1'b0;
		wait_n(5);
		chk(32'(rem_n), 32'h1);
		chk({30'h0, bg, br}, 32'h1);
		locked <= 1'b1;
		// switch against software default mode
		for (int i = 0; i < 4; i++) begin
			dip <= i[1];
			wr(OFS_CTRL, 32'(i[0]));
			wait_n(4);
			u_cpu_bus_model.rd(OFS_STATUS, q);
			chk({30'h0, q[ST_MISMATCH_BIT], q[ST_SW_HOLD_BIT]}, {30'h0, i[0] == i[1], ~i[1]});
		end
		// clock enable low freezes the lock path and its indicator
		ce <= 1'b0;
		locked <= 1'b0;
		wait_n(5);
		chk({30'h0, bg, br}, 32'h2);
		chk(32'(rem_n), 32'h1);
		locked <= 1'b1;
		ce <= 1'b1;
		// module fault forces outputs off and blinks the block indicator
		wr(OFS_CTRL, 32'h2);
		wait_n(3);
		chk(drive, 32'h0);
		on_n = 0;
		repeat (12) begin
			@(posedge clk);
			on_n += int'(bg === 1'b1);
		end
		chk({31'h0, on_n > 0 && on_n < 12}, 32'h1);
		u_cpu_bus_model.set_mode(1'b1);
		wait_n(3);
		chk(drive, cmd);
		// communication loss in force off mode
		wr(OFS_TIMEOUT, 32'd40);
		rd_chk(OFS_TIMEOUT, 32'd40);
		wr(OFS_OUT_CMD, cmd);
		wait_n(30);
		chk(drive, cmd);
		wait_n(30);
		chk(drive, 32'h0);
		chk(pg, 32'h0);
		u_cpu_bus_model.rd(OFS_STATUS, q);
		chk({31'h0, q[ST_LOST_BIT]}, 32'h1);
		// communication loss in hold mode, then fresh data
		dip <= 1'b0;
		u_cpu_bus_model.set_mode(1'b0);
		wr(OFS_OUT_CMD, cmd);
		wait_n(60);
		chk(drive, cmd);
		chk(pg, 32'h0);
		cmd = ~cmd;
		wr(OFS_OUT_CMD, cmd);
		wait_n(3);
		chk(pg, cmd);
		chk(drive, cmd);
		chk({31'h0, no_answer}, 32'h0);
		conclude();
	end
endmodule
`default_nettype wire
